// ### hdl/afm_output_formatter.sv
// Output formatting stage of a 14-bit sampling converter with forwarded sample clock
`timescale 1ns/1ps
`include "afm_consts.svh"

module afm_output_formatter
  import afm_pkg::*;
#(
  parameter int SLEEP_SETTLE_CYCLES = `AFM_SLEEP_WAKE_MS * 1000 * `AFM_CLK_MHZ,
  parameter int NAP_SETTLE_CYCLES   = `AFM_NAP_SETTLE_US * `AFM_CLK_MHZ
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [6:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  input  wire logic        encodeClk,
  input  wire logic [13:0] coreCode,
  input  wire logic        coreAboveRange,
  input  wire logic        coreBelowRange,
  input  wire logic        parallelSelect,
  input  wire logic        parDcsPin,
  input  wire logic        parModePin,
  input  wire logic        parSleepPin,
  output logic      [13:0] sampleWordBits,
  output logic      [6:0]  ddrBitPairLane,
  output logic             rangeExceededFlag,
  output logic             forwardedSampleClock,
  output logic             outEnableN,
  output logic             lvdsSelect,
  output logic             ddrSelect,
  output logic      [12:0] lvdsDriveMicroAmp,
  output logic             internalTermOn,
  output logic             dutyStabilizerOn,
  output logic             coreSleep,
  output logic             coreNap,
  output logic             outputUnsettled
);

  afm_state_t  st;
  afm_state_t  next_st;

  logic        encRise;
  logic        parMode;
  logic        effDcs;
  logic [1:0]  effMode;
  logic        effSleep;
  logic        effNap;
  logic        effInv;
  logic [1:0]  effPhase;
  logic        effTerm;
  logic [2:0]  effCur;
  logic        effOff;
  logic        effTwos;
  logic        effRand;
  logic        effAbp;
  logic [2:0]  effTp;
  logic        effDdr;
  logic        overRange;
  logic [13:0] clampedCode;
  logic [13:0] twosCode;
  logic [13:0] randCode;
  logic [13:0] abpCode;
  logic [14:0] fmtWord;
  logic [6:0]  evenFmt;
  logic [6:0]  oddWord;
  logic [6:0]  evenWord;
  logic [12:0] baseUa;
  logic [15:0] boostUa;
  logic [7:0]  nextCnt;
  logic [9:0]  delayProd;
  logic [6:0]  delay;
  logic [6:0]  half;
  logic [8:0]  pos;
  logic        rawClk;

  // Rising edge of the synchronised encode clock; stage 0 is read only by stage 1
  assign encRise = st.encSync[1] & ~st.encSync[2];

  // Pins rule in parallel mode; nap and fine settings only exist in registers
  assign parMode  = st.parSelSync[1];
  assign effDcs   = parMode ? st.dcsSync[1] : st.regTiming[`AFM_TIM_DCS];
  assign effMode  = parMode ? {1'b0, st.modeSync[1]} : st.regMode[1:0];
  assign effSleep = parMode ? st.sleepSync[1] : (st.regPower == `AFM_PWR_SLEEP_CODE);
  assign effNap   = ~parMode & (st.regPower == `AFM_PWR_NAP_CODE);
  assign effInv   = ~parMode & st.regTiming[`AFM_TIM_INV];
  assign effPhase = parMode ? 2'b00 : st.regTiming[`AFM_TIM_PHASE_LO +: 2];
  assign effTerm  = ~parMode & st.regMode[`AFM_MODE_TERM];
  assign effCur   = parMode ? 3'b000 : st.regMode[`AFM_MODE_CUR_LO +: 3];
  assign effOff   = ~parMode & st.regMode[`AFM_MODE_OFF];
  assign effTwos  = ~parMode & st.regFormat[`AFM_FMT_TWOS];
  assign effRand  = ~parMode & st.regFormat[`AFM_FMT_RAND];
  assign effAbp   = ~parMode & st.regFormat[`AFM_FMT_ABP];
  assign effTp    = parMode ? `AFM_TP_OFF : st.regFormat[`AFM_FMT_TP_LO +: 3];
  assign effDdr   = (effMode == `AFM_OM_DDR_LVDS) | (effMode == `AFM_OM_DDR_CMOS);

  // Clamp beyond full scale and raise the flag on the same sample
  assign overRange   = coreAboveRange | coreBelowRange;
  assign clampedCode = coreAboveRange ? `AFM_CODE_HIGH :
                       (coreBelowRange ? `AFM_CODE_LOW : coreCode);

  // Formatting chain in fixed order
  assign twosCode = (effTwos & ~effAbp) ? {~clampedCode[13], clampedCode[12:0]} : clampedCode;
  assign randCode = effRand ? {twosCode[13:1] ^ {13{twosCode[0]}}, twosCode[0]} : twosCode;
  assign abpCode  = effAbp ? (randCode ^ `AFM_ODD_MASK) : randCode;

  // Test pattern substitution last, flag in bit 14
  always_comb begin
    case (effTp)
      `AFM_TP_ONES:  fmtWord = {1'b1, `AFM_CODE_HIGH};
      `AFM_TP_ZEROS: fmtWord = {1'b0, `AFM_CODE_LOW};
      `AFM_TP_ALT:   fmtWord = st.altPhase ? {1'b0, `AFM_CODE_LOW} : {1'b1, `AFM_CODE_HIGH};
      `AFM_TP_CHECK: fmtWord = st.altPhase ? `AFM_CHECK_B : `AFM_CHECK_A;
      default:       fmtWord = {overRange, abpCode};
    endcase
  end

  // Adjacent bit pairs per DDR lane
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_lane
      assign evenFmt[g]  = fmtWord[2*g];
      assign oddWord[g]  = st.word[2*g+1];
      assign evenWord[g] = st.word[2*g];
    end
  endgenerate

  // LVDS driver current table
  always_comb begin
    case (effCur)
      3'b000:  baseUa = `AFM_UA_3500;
      3'b001:  baseUa = `AFM_UA_4000;
      3'b010:  baseUa = `AFM_UA_4500;
      3'b100:  baseUa = `AFM_UA_3000;
      3'b101:  baseUa = `AFM_UA_2500;
      3'b110:  baseUa = `AFM_UA_2100;
      3'b111:  baseUa = `AFM_UA_1750;
      default: baseUa = `AFM_UA_3500;
    endcase
  end
  assign boostUa = ({3'b000, baseUa} * `AFM_TERM_MUL) / `AFM_TERM_DIV;

  // Sample-period counter and forwarded clock phase position
  assign nextCnt   = encRise ? 8'h00 : ((st.phaseCnt == `AFM_CNT_SAT) ? st.phaseCnt : st.phaseCnt + 8'h01);
  assign delayProd = {2'b00, st.period} * {8'h00, effPhase};
  assign delay     = delayProd[9:3];
  assign half      = st.period[7:1];
  assign pos       = (nextCnt >= {1'b0, delay}) ? ({1'b0, nextCnt} - {2'b00, delay}) :
                     ({1'b0, nextCnt} + {1'b0, st.period} - {2'b00, delay});
  assign rawClk    = (pos >= {2'b00, half});

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.rdData     = 8'h00;
    next_st.encSync    = {st.encSync[1:0], encodeClk};
    next_st.parSelSync = {st.parSelSync[0], parallelSelect};
    next_st.dcsSync    = {st.dcsSync[0], parDcsPin};
    next_st.modeSync   = {st.modeSync[0], parModePin};
    next_st.sleepSync  = {st.sleepSync[0], parSleepPin};

    // Register writes, soft reset clears every mode register
    if (regWrite) begin
      case (regAddr)
        `AFM_ADDR_RESET: begin
          if (regWrData[`AFM_RESET_BIT]) begin
            next_st.regPower  = 2'b00;
            next_st.regTiming = 4'h0;
            next_st.regMode   = 7'h00;
            next_st.regFormat = 6'h00;
          end
        end
        `AFM_ADDR_POWER:  next_st.regPower  = regWrData[1:0];
        `AFM_ADDR_TIMING: next_st.regTiming = regWrData[3:0];
        `AFM_ADDR_MODE:   next_st.regMode   = regWrData[6:0];
        `AFM_ADDR_FORMAT: next_st.regFormat = regWrData[5:0];
        default: ;
      endcase
    end

    // Register reads, reset register and holes read as zero
    if (regRead) begin
      case (regAddr)
        `AFM_ADDR_POWER:  next_st.rdData = {6'h00, st.regPower};
        `AFM_ADDR_TIMING: next_st.rdData = {4'h0, st.regTiming};
        `AFM_ADDR_MODE:   next_st.rdData = {1'b0, st.regMode};
        `AFM_ADDR_FORMAT: next_st.rdData = {2'b00, st.regFormat};
        default:          next_st.rdData = 8'h00;
      endcase
    end

    // Period measurement
    next_st.phaseCnt = nextCnt;
    if (encRise) begin
      next_st.period = st.phaseCnt + 8'h01;
    end

    // Sample launch on each rising encode edge while the core runs
    if (encRise && st.power == AFM_PWR_RUN) begin
      next_st.word           = fmtWord[13:0];
      next_st.flag           = fmtWord[14];
      next_st.altPhase       = ~st.altPhase;
      next_st.rangeFlag      = fmtWord[14];
      next_st.sampleWordBits = effDdr ? 14'h0000 : fmtWord[13:0];
      next_st.ddrLane        = effDdr ? evenFmt : 7'h00;
    end else if (!encRise && effDdr && nextCnt == {1'b0, half}) begin
      next_st.ddrLane = oddWord;
    end

    // Forwarded clock with delay and independent inversion
    next_st.fwdClk = rawClk ^ effInv;

    // Output enable and driver settings
    next_st.outEnableN = effOff;
    next_st.lvdsDrive  = effTerm ? boostUa[12:0] : baseUa;
    next_st.termOn     = effTerm;
    next_st.lvdsSel    = (effMode == `AFM_OM_DDR_LVDS);
    next_st.ddrSel     = effDdr;
    next_st.dcsOn      = effDcs;

    // Power state machine and wake-up settling indication
    case (st.power)
      AFM_PWR_RUN: begin
        if (effSleep) begin
          next_st.power = AFM_PWR_SLEEP;
        end else if (effNap) begin
          next_st.power = AFM_PWR_NAP;
        end
      end
      AFM_PWR_NAP: begin
        if (effSleep) begin
          next_st.power = AFM_PWR_SLEEP;
        end else if (!effNap) begin
          next_st.power     = AFM_PWR_RUN;
          next_st.settleCnt = 18'(NAP_SETTLE_CYCLES);
          next_st.napEdges  = `AFM_NAP_WAKE_EDGES;
        end
      end
      AFM_PWR_SLEEP: begin
        if (!effSleep) begin
          next_st.power     = effNap ? AFM_PWR_NAP : AFM_PWR_RUN;
          next_st.settleCnt = 18'(SLEEP_SETTLE_CYCLES);
        end
      end
      default: next_st.power = AFM_PWR_RUN;
    endcase
    if (st.power == AFM_PWR_RUN) begin
      if (st.settleCnt != 18'h0_0000) begin
        next_st.settleCnt = st.settleCnt - 18'h0_0001;
      end
      if (encRise && st.napEdges != 7'h00) begin
        next_st.napEdges = st.napEdges - 7'h01;
      end
    end
    next_st.unsettled = (st.power != AFM_PWR_RUN) || (st.settleCnt != 18'h0_0000) || (st.napEdges != 7'h00);
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st       <= '0;
      st.power <= AFM_PWR_RUN;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign regRdData            = st.rdData;
  assign sampleWordBits       = st.sampleWordBits;
  assign ddrBitPairLane       = st.ddrLane;
  assign rangeExceededFlag    = st.rangeFlag;
  assign forwardedSampleClock = st.fwdClk;
  assign outEnableN           = st.outEnableN;
  assign lvdsSelect           = st.lvdsSel;
  assign ddrSelect            = st.ddrSel;
  assign lvdsDriveMicroAmp    = st.lvdsDrive;
  assign internalTermOn       = st.termOn;
  assign dutyStabilizerOn     = st.dcsOn;
  assign coreSleep            = st.power[2];
  assign coreNap              = st.power[1];
  assign outputUnsettled      = st.unsettled;

  // Checks on the formatting, clocking and configuration paths
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take;
    encRise && st.power == AFM_PWR_RUN && effTp == `AFM_TP_OFF;
  endsequence

  sequence s_plain;
    !effTwos && !effRand && !effAbp;
  endsequence

  a_flag_latency: assert property (s_take |=> st.flag == $past(overRange))
    else $error("range flag does not follow its sample");
  a_clamp_high: assert property (s_take ##0 s_plain ##0 coreAboveRange |=>
                                 st.word == `AFM_CODE_HIGH && st.flag)
    else $error("over range sample not clamped high");
  a_twos_msb: assert property (s_take ##0 effTwos && !effRand && !effAbp |=>
                               st.word == {~$past(clampedCode[13]), $past(clampedCode[12:0])})
    else $error("two's complement word wrong");
  a_rand_xor: assert property (s_take ##0 !effTwos && !effAbp |=>
                               st.word == ($past(effRand) ? {$past(clampedCode[13:1]) ^ {13{$past(clampedCode[0])}},
                                   $past(clampedCode[0])} : $past(clampedCode)))
    else $error("randomized word wrong");
  a_abp_odd: assert property (s_take ##0 effAbp && !effRand |=> st.word == ($past(clampedCode) ^ `AFM_ODD_MASK))
    else $error("alternate polarity word wrong or format not offset binary");
  a_rand_lsb: assert property (s_take ##0 effRand |=> st.word[0] == $past(clampedCode[0]))
    else $error("randomizer altered the LSB");
  a_test_ones: assert property (encRise && st.power == AFM_PWR_RUN && effTp == `AFM_TP_ONES
                                |=> st.word == `AFM_CODE_HIGH && st.flag)
    else $error("all ones pattern not forced");
  a_ddr_even: assert property (encRise && st.power == AFM_PWR_RUN && effDdr |=> st.ddrLane == evenWord)
    else $error("DDR lanes do not carry even bits first");
  a_clk_falls: assert property (encRise && effPhase == 2'b00 && !effInv && st.period > 8'h03 |=> !st.fwdClk ##1 !st.fwdClk)
    else $error("forwarded clock not low after launch");
  a_out_disable: assert property (effOff |=> outEnableN)
    else $error("outputs still enabled while disabled");
  a_term_boost: assert property (effTerm && effCur == 3'b000 |=> lvdsDriveMicroAmp == 13'h15E0)
    else $error("terminated drive not 5.6 mA");
  a_drive_min: assert property (!effTerm && effCur == 3'b111 |=> lvdsDriveMicroAmp == 13'h06D6)
    else $error("lowest drive current not 1.75 mA");
  a_par_no_nap: assert property (parMode && st.power == AFM_PWR_RUN |=> !coreNap)
    else $error("nap entered from pin configuration");

  // Checks on word holding, lane switching and alternating test patterns
  sequence s_half;
    !encRise && effDdr && nextCnt == {1'b0, half};
  endsequence

  a_word_steady: assert property (!(encRise && st.power == AFM_PWR_RUN) |=>
                                  $stable(st.word) && $stable(st.flag))
    else $error("sample word changed between launches");
  a_ddr_odd: assert property (s_half ##0 effPhase == 2'b00 && !effInv |=>
                              st.fwdClk && st.ddrLane == oddWord)
    else $error("DDR lanes do not switch to odd bits on the clock rise");
  a_ddr_word_zero: assert property (encRise && st.power == AFM_PWR_RUN && effDdr |=>
                                    st.sampleWordBits == 14'h0000)
    else $error("full-rate word still driven in DDR mode");
  a_alt_pattern: assert property (encRise && st.power == AFM_PWR_RUN && effTp == `AFM_TP_ALT |=>
                                  {st.flag, st.word} == ($past(st.altPhase) ? 15'h0000 : 15'h7FFF))
    else $error("alternating pattern out of step");
  a_check_pattern: assert property (encRise && st.power == AFM_PWR_RUN && effTp == `AFM_TP_CHECK |=>
                                    {st.flag, st.word} == ($past(st.altPhase) ? 15'h2AAA : 15'h5555))
    else $error("checkerboard pattern out of step");

endmodule : afm_output_formatter

// ### hdl/afm_consts.svh
// Constants for the converter output formatter: offsets, fields, codes and timing
`ifndef AFM_CONSTS_SVH
`define AFM_CONSTS_SVH

// Register offsets on the plain register port
`define AFM_ADDR_RESET     7'h00
`define AFM_ADDR_POWER     7'h01
`define AFM_ADDR_TIMING    7'h02
`define AFM_ADDR_MODE      7'h03
`define AFM_ADDR_FORMAT    7'h04

// Field positions
`define AFM_RESET_BIT      7
`define AFM_TIM_DCS        0
`define AFM_TIM_PHASE_LO   1
`define AFM_TIM_INV        3
`define AFM_MODE_OFF       2
`define AFM_MODE_TERM      3
`define AFM_MODE_CUR_LO    4
`define AFM_FMT_TWOS       0
`define AFM_FMT_RAND       1
`define AFM_FMT_ABP        2
`define AFM_FMT_TP_LO      3

// Power and output mode codes
`define AFM_PWR_NAP_CODE   2'b01
`define AFM_PWR_SLEEP_CODE 2'b11
`define AFM_OM_FULL_CMOS   2'b00
`define AFM_OM_DDR_LVDS    2'b01
`define AFM_OM_DDR_CMOS    2'b10

// Test pattern selections
`define AFM_TP_OFF         3'b000
`define AFM_TP_ONES        3'b001
`define AFM_TP_ZEROS       3'b010
`define AFM_TP_ALT         3'b011
`define AFM_TP_CHECK       3'b100

// Sample codes (flag in bit 14 for the 15-bit test words)
`define AFM_CODE_HIGH      14'h3FFF
`define AFM_CODE_LOW       14'h0000
`define AFM_ODD_MASK       14'h2AAA
`define AFM_CHECK_A        15'h5555
`define AFM_CHECK_B        15'h2AAA

// LVDS driver current in microamps, and termination boost of 8/5
`define AFM_UA_3500        13'h0DAC
`define AFM_UA_4000        13'h0FA0
`define AFM_UA_4500        13'h1194
`define AFM_UA_3000        13'h0BB8
`define AFM_UA_2500        13'h09C4
`define AFM_UA_2100        13'h0834
`define AFM_UA_1750        13'h06D6
`define AFM_TERM_MUL       16'h0008
`define AFM_TERM_DIV       16'h0005

// Timing
`define AFM_CLK_MHZ        100
`define AFM_SLEEP_WAKE_MS  2
`define AFM_NAP_SETTLE_US  50
`define AFM_NAP_WAKE_EDGES 7'h64
`define AFM_CNT_SAT        8'hFE

`endif

// ### hdl/afm_pkg.sv
// Types for the converter output formatter
package afm_pkg;

  typedef enum logic [2:0] {
    AFM_PWR_RUN   = 3'b001,
    AFM_PWR_NAP   = 3'b010,
    AFM_PWR_SLEEP = 3'b100
  } afm_power_t;

  typedef struct packed {
    logic [1:0]  regPower;
    logic [3:0]  regTiming;
    logic [6:0]  regMode;
    logic [5:0]  regFormat;
    logic [7:0]  rdData;
    logic [2:0]  encSync;
    logic [1:0]  parSelSync;
    logic [1:0]  dcsSync;
    logic [1:0]  modeSync;
    logic [1:0]  sleepSync;
    logic [7:0]  phaseCnt;
    logic [7:0]  period;
    logic [13:0] word;
    logic        flag;
    logic        altPhase;
    logic [13:0] sampleWordBits;
    logic [6:0]  ddrLane;
    logic        rangeFlag;
    logic        fwdClk;
    logic        outEnableN;
    logic [12:0] lvdsDrive;
    logic        termOn;
    logic        lvdsSel;
    logic        ddrSel;
    logic        dcsOn;
    afm_power_t  power;
    logic [17:0] settleCnt;
    logic [6:0]  napEdges;
    logic        unsettled;
  } afm_state_t;

endpackage : afm_pkg

// ### hdl/afm_output_formatter_unused_note.sv
// Spare design file that holds no logic; the formatter module carries all of it

// ### verif/afm_capture_rx.sv
// Receiver model that latches each forwarded sample while hold is low and undoes the randomizer and odd-bit inversion
`timescale 1ns/1ps

module afm_capture_rx (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        fwdClk,
  input  wire logic [13:0] word,
  input  wire logic        flag,
  input  wire logic        hold,
  input  wire logic        rndOn,
  input  wire logic        abpOn,
  output logic      [14:0] capRaw,
  output logic      [14:0] prevRaw,
  output logic      [13:0] capData
);
  logic        lastClk;
  logic [13:0] dec;

  // Re-invert odd bits, then strip the randomizer
  always_comb begin
    dec = abpOn ? word ^ 14'h2AAA : word;
    dec[13:1] = rndOn ? dec[13:1] ^ {13{dec[0]}} : dec[13:1];
  end

  // Latch on the rising forwarded clock; output still settling is dropped
  always_ff @(posedge clk) begin
    lastClk <= rst_n & fwdClk;
    if (rst_n && fwdClk && !lastClk && !hold) begin
      prevRaw <= capRaw;
      capRaw  <= {flag, word};
      capData <= dec;
    end
  end
endmodule : afm_capture_rx

// ### verif/adc_output_formatter_tb.sv
// Self-checking bench for the converter output formatter
`timescale 1ns/1ps

module adc_output_formatter_tb;
  logic        clk, rst_n, regWrite, regRead, encodeClk, coreAbove, coreBelow, parSel, parDcs, parMode, parSleep;
  logic        rxRnd, rxAbp, flag, fwdClk, oeN, lvdsSel, ddrSel, termOn, dcsOn, sleepOn, napOn, unsettled;
  logic [6:0]  regAddr, lane;
  logic [7:0]  regWrData, regRdData;
  logic [13:0] coreCode, word, capData;
  logic [14:0] capRaw, prevRaw;
  logic [12:0] drive;
  int          mismatches, comparisons;

  afm_output_formatter #(.SLEEP_SETTLE_CYCLES(50), .NAP_SETTLE_CYCLES(20)) u_dut (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .encodeClk(encodeClk), .coreCode(coreCode), .coreAboveRange(coreAbove),
    .coreBelowRange(coreBelow), .parallelSelect(parSel), .parDcsPin(parDcs), .parModePin(parMode),
    .parSleepPin(parSleep), .sampleWordBits(word), .ddrBitPairLane(lane), .rangeExceededFlag(flag),
    .forwardedSampleClock(fwdClk), .outEnableN(oeN), .lvdsSelect(lvdsSel), .ddrSelect(ddrSel),
    .lvdsDriveMicroAmp(drive), .internalTermOn(termOn), .dutyStabilizerOn(dcsOn), .coreSleep(sleepOn),
    .coreNap(napOn), .outputUnsettled(unsettled));
  afm_capture_rx u_rx (.clk(clk), .rst_n(rst_n), .fwdClk(fwdClk), .word(word), .flag(flag), .hold(unsettled),
    .rndOn(rxRnd), .abpOn(rxAbp), .capRaw(capRaw), .prevRaw(prevRaw), .capData(capData));

  // System clock, and an encode clock of unrelated phase
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    encodeClk = 1'b0;
    #3;
    forever #80 encodeClk = ~encodeClk;
  end

  // Watchdog against a hung run
  initial begin
    #500_000;
    mismatches++;
    wrap_up;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Register bus cycles; the trailing edge keeps strobes apart
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read data are taken mid-cycle, in the one cycle where they stand
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    check(16'(regRdData), 16'(exp));
    @(posedge clk);
  endtask : rd

  task automatic waitfor(ref logic s, input logic v, input int lim);
    for (int n = 0; n < lim && s !== v; n++) @(posedge clk);
  endtask : waitfor

  // Expected word: two's complement, randomizer, then odd-bit inversion
  function automatic logic [13:0] fmt(input logic [13:0] c, input logic [2:0] f);
    logic [13:0] w;
    w = (f[0] && !f[2]) ? c ^ 14'h2000 : c;
    if (f[1]) w[13:1] = w[13:1] ^ {13{w[0]}};
    return f[2] ? w ^ 14'h2AAA : w;
  endfunction : fmt

  task automatic t_regs;
    check(16'(drive), 16'd3500);
    wr(7'h02, 8'h0F);
    rd(7'h02, 8'h0F);
    check(16'(dcsOn), 16'h0001);
    rd(7'h10, 8'h00);
    wr(7'h00, 8'h80);
    rd(7'h02, 8'h00);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_drive;
    int ua[8] = '{3500, 4000, 4500, 3500, 3000, 2500, 2100, 1750};
    for (int i = 0; i < 16; i++) begin
      wr(7'h03, {1'b0, 3'(i), i[3], 3'b001});
      repeat (3) @(posedge clk);
      check(16'(drive), 16'(i[3] ? ua[i % 8] * 8 / 5 : ua[i % 8]));
      check(16'(termOn), 16'(i[3]));
    end
    $display("t_drive done");
  endtask : t_drive

  task automatic t_format;
    logic [13:0] codes[4] = '{14'h2000, 14'h3FFF, 14'h0001, 14'h1234};
    wr(7'h03, 8'h00);
    for (int f = 0; f < 8; f++) begin
      wr(7'h04, 8'(f));
      rxRnd <= f[1];
      rxAbp <= f[2];
      for (int k = 0; k < 4; k++) begin
        coreCode <= codes[k];
        repeat (56) @(posedge clk);
        check(16'(capRaw), 16'(fmt(codes[k], 3'(f))));
        check(16'(capData), 16'((f[0] && !f[2]) ? codes[k] ^ 14'h2000 : codes[k]));
      end
    end
    $display("t_format done");
  endtask : t_format

  task automatic t_range;
    for (int t = 0; t < 2; t++) begin
      wr(7'h04, t ? 8'h03 : 8'h00);
      coreAbove <= 1'b1;
      repeat (56) @(posedge clk);
      check(16'(capRaw), t ? 16'h6001 : 16'h7FFF);
      coreAbove <= 1'b0;
      coreBelow <= 1'b1;
      repeat (56) @(posedge clk);
      check(16'(capRaw), t ? 16'h6000 : 16'h4000);
      coreBelow <= 1'b0;
    end
    $display("t_range done");
  endtask : t_range

  task automatic t_test;
    for (int p = 1; p < 5; p++) begin
      wr(7'h04, {2'b00, 3'(p), 3'b111});
      repeat (56) @(posedge clk);
      if (p == 1) check(16'(capRaw), 16'h7FFF);
      if (p == 2) check(16'(capRaw), 16'h0000);
      if (p == 3) check(16'(capRaw == 15'h7FFF || capRaw == 15'h0000), 16'h0001);
      if (p == 4) check(16'(capRaw == 15'h5555 || capRaw == 15'h2AAA), 16'h0001);
      if (p > 2) check(16'(capRaw ^ prevRaw), 16'h7FFF);
    end
    wr(7'h04, 8'h00);
    $display("t_test done");
  endtask : t_test

  // Cycles from a word change to the forwarded clock rise, per phase code and inversion
  task automatic t_phase;
    logic w0, prev;
    int   n;
    wr(7'h04, 8'h18);
    for (int c = 0; c < 8; c++) begin
      wr(7'h02, {4'h0, c[2], c[1:0], 1'b1});
      repeat (40) @(posedge clk);
      @(negedge clk);
      w0 = word[0];
      for (n = 0; n < 40 && word[0] === w0; n++) begin
        prev = fwdClk;
        @(negedge clk);
      end
      for (n = 0; n < 20 && !(fwdClk === 1'b1 && prev === 1'b0); n++) begin
        prev = fwdClk;
        @(negedge clk);
      end
      check(16'(n), 16'((c[2] ? 0 : 8) + 2 * c[1:0]));
      @(posedge clk);
    end
    wr(7'h02, 8'h00);
    wr(7'h04, 8'h00);
    $display("t_phase done");
  endtask : t_phase

  task automatic t_ddr;
    coreCode <= 14'h1234;
    for (int m = 1; m < 3; m++) begin
      wr(7'h03, 8'(m));
      repeat (56) @(posedge clk);
      check({ddrSel, lvdsSel, word}, m == 1 ? 16'hC000 : 16'h8000);
      waitfor(fwdClk, 1'b1, 40);
      check(16'(lane), 16'h0014);
      waitfor(fwdClk, 1'b0, 40);
      check(16'(lane), 16'h0046);
    end
    wr(7'h03, 8'h04);
    repeat (3) @(posedge clk);
    check(16'(oeN), 16'h0001);
    wr(7'h03, 8'h00);
    $display("t_ddr done");
  endtask : t_ddr

  task automatic t_power;
    for (int s = 0; s < 2; s++) begin
      wr(7'h01, s ? 8'h03 : 8'h01);
      repeat (3) @(posedge clk);
      check(16'({sleepOn, napOn, unsettled}), s ? 16'h0005 : 16'h0003);
      wr(7'h01, 8'h00);
      repeat (30) @(posedge clk);
      check(16'(unsettled), 16'h0001);
      waitfor(unsettled, 1'b0, 2500);
      check(16'(unsettled), 16'h0000);
    end
    parSel <= 1'b1;
    parSleep <= 1'b1;
    parMode <= 1'b1;
    parDcs <= 1'b1;
    wr(7'h01, 8'h01);
    repeat (8) @(posedge clk);
    check(16'({sleepOn, napOn, lvdsSel, dcsOn}), 16'h000B);
    check(16'(drive), 16'd3500);
    $display("t_power done");
  endtask : t_power

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    {regWrite, regRead, coreAbove, coreBelow, parSel, parDcs, parMode, parSleep, rxRnd, rxAbp} = '0;
    {regAddr, regWrData, coreCode} = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_drive;
    t_format;
    t_range;
    t_test;
    t_phase;
    t_ddr;
    t_power;
    wrap_up;
  end
endmodule : adc_output_formatter_tb
